// ### design/psm_pkg.sv
// constants and types for the panel status and mode logic
package psm_pkg;

  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_SPEED_MATCH = 8'h00;
  localparam logic [7:0] ADDR_POS_DONE = 8'h04;
  localparam logic [7:0] ADDR_ROT_SPEED = 8'h08;
  localparam logic [7:0] ADDR_PARAM = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // ------------------------------------------------------------
  // values after reset
  // ------------------------------------------------------------
  localparam logic [15:0] RST_SPEED_MATCH = 16'h000a;
  localparam logic [15:0] RST_POS_DONE = 16'h000a;
  localparam logic [15:0] RST_ROT_SPEED = 16'h0014;
  localparam logic [15:0] RST_PARAM = 16'h0000;

  // ------------------------------------------------------------
  // fixed limits
  // ------------------------------------------------------------
  localparam logic [7:0] TORQUE_REF_PCT = 8'h0a;
  localparam logic [15:0] PARAM_MIN = 16'h0000;
  localparam logic [15:0] PARAM_MAX = 16'hffff;

  // ------------------------------------------------------------
  // status register fields
  // ------------------------------------------------------------
  localparam int STS_MODE_LSB = 0;
  localparam int STS_EDIT_BIT = 4;
  localparam int STS_BITS_LSB = 8;
  localparam int STS_CODE_LSB = 16;
  localparam int STS_ALARM_BIT = 24;

  // ------------------------------------------------------------
  // indicator bit positions
  // ------------------------------------------------------------
  localparam int IND_MATCH = 0;
  localparam int IND_BASE_BLOCK = 1;
  localparam int IND_CTRL_POWER = 2;
  localparam int IND_REF = 3;
  localparam int IND_TORQUE_CLR = 4;
  localparam int IND_POWER_READY = 5;
  localparam int IND_ROTATION = 6;

  // ------------------------------------------------------------
  // status codes
  // ------------------------------------------------------------
  localparam logic [7:0] CODE_BASEBLOCK = 8'hb0;
  localparam logic [7:0] CODE_RUN = 8'hc0;
  localparam logic [7:0] CODE_FWD_PROHIBIT = 8'hf0;
  localparam logic [7:0] CODE_REV_PROHIBIT = 8'he0;

  // ------------------------------------------------------------
  // control modes and bus answers
  // ------------------------------------------------------------
  localparam logic [1:0] CTRL_SPEED = 2'h0;
  localparam logic [1:0] CTRL_TORQUE = 2'h1;
  localparam logic [1:0] CTRL_POSITION = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ------------------------------------------------------------
  // synchronised pin indices
  // ------------------------------------------------------------
  localparam int PIN_COUNT = 7;
  localparam int PIN_MODE = 0;
  localparam int PIN_ENTER = 1;
  localparam int PIN_INC = 2;
  localparam int PIN_DEC = 3;
  localparam int PIN_ALM_CLR = 4;
  localparam int PIN_FWD = 5;
  localparam int PIN_REV = 6;

  typedef enum logic [3:0] {
    MODE_STATUS = 4'h1,
    MODE_PARAM = 4'h2,
    MODE_MONITOR = 4'h4,
    MODE_UTILITY = 4'h8
  } psm_mode_t;

endpackage : psm_pkg

// ### design/psm_panel.sv
// front-panel mode, editing, alarm clear and status display logic
`timescale 1ns/10ps

// Notes on behaviour
// [RL1] each mode key press outside editing steps to the next basic mode
// [RL2] order: status, parameter, monitor, utility, then back to status
// [RL3] status display mode is entered out of reset
// [RL4] enter key in status display mode clears the pending alarm
// [RL5] alarm clear input clears the pending alarm like the enter key
// [RL6] mode key while editing saves the value and leaves editing
// [RL7] while editing, increment adds one step, decrement subtracts one
// [RL8] control mode selects speed/torque or position indicator meanings
// [RL9] speed match lights at error up to threshold; always lit in torque
// [RL10] position done lights when position error is below threshold
// [RL11] base block indicator lit while blocked, dark at servo on
// [RL12] control power indicator follows the control power status
// [RL13] speed reference indicator lit above rotation threshold
// [RL14] reference pulse indicator lit while pulses arrive
// [RL15] torque reference indicator lit above ten percent rated torque
// [RL16] clear indicator follows the error counter clear signal
// [RL17] power ready lit only while main power is on and normal
// [RL18] rotation indicator lit when motor speed exceeds rotation threshold
// [RL19] code shows run at servo on, baseblock at servo off
// [RL20] forward or reverse prohibited code while that limit input is off
// [RL21] a pending alarm shows its number instead of the normal codes
module psm_panel (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic mode_key,
  input wire logic enter_key,
  input wire logic increment_key,
  input wire logic decrement_key,
  input wire logic alarm_clear_input,
  input wire logic forward_limit_input,
  input wire logic reverse_limit_input,
  input wire logic [1:0] control_mode,
  input wire logic [15:0] speed_error,
  input wire logic [15:0] position_error,
  input wire logic servo_on,
  input wire logic base_block,
  input wire logic control_power_ok,
  input wire logic [15:0] speed_reference,
  input wire logic [7:0] torque_reference_pct,
  input wire logic reference_pulse_active,
  input wire logic error_clear_active,
  input wire logic main_power_ok,
  input wire logic [15:0] motor_speed,
  input wire logic alarm_pending,
  input wire logic [7:0] alarm_number,
  output logic [3:0] basic_mode,
  output logic editing,
  output logic [15:0] edit_value,
  output logic param_commit,
  output logic alarm_clear,
  output logic [6:0] status_bits,
  output logic [7:0] status_code,
  output logic status_alarm
);

  // ------------------------------------------------------------
  // pin synchronisers and edge detect
  // ------------------------------------------------------------
  logic [psm_pkg::PIN_COUNT-1:0] pin_raw;
  logic [psm_pkg::PIN_COUNT-1:0] meta_q;
  logic [psm_pkg::PIN_COUNT-1:0] sync_q;
  logic [psm_pkg::PIN_COUNT-1:0] prev_q;
  logic [psm_pkg::PIN_COUNT-1:0] rise;

  assign pin_raw = {reverse_limit_input, forward_limit_input, alarm_clear_input,
                    decrement_key, increment_key, enter_key, mode_key};

  genvar gi;
  generate
    for (gi = 0; gi < psm_pkg::PIN_COUNT; gi++) begin : g_sync
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
          prev_q[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= pin_raw[gi];
          sync_q[gi] <= meta_q[gi];
          prev_q[gi] <= sync_q[gi];
        end
      end
      assign rise[gi] = sync_q[gi] & ~prev_q[gi];
    end
  endgenerate

  wire mode_press = rise[psm_pkg::PIN_MODE];
  wire enter_press = rise[psm_pkg::PIN_ENTER];
  wire inc_press = rise[psm_pkg::PIN_INC];
  wire dec_press = rise[psm_pkg::PIN_DEC];
  wire alm_clr_press = rise[psm_pkg::PIN_ALM_CLR];
  wire fwd_ok = sync_q[psm_pkg::PIN_FWD];
  wire rev_ok = sync_q[psm_pkg::PIN_REV];

  // ------------------------------------------------------------
  // basic mode sequencer
  // ------------------------------------------------------------
  psm_pkg::psm_mode_t mode_q;
  psm_pkg::psm_mode_t mode_step;
  psm_pkg::psm_mode_t mode_d;
  logic edit_q;
  logic edit_d;
  logic [15:0] edit_val_q;
  logic [15:0] edit_val_d;
  logic commit_q;
  logic clear_q;
  logic [15:0] param_q;

  always_comb begin
    case (mode_q)
      psm_pkg::MODE_STATUS: mode_step = psm_pkg::MODE_PARAM; // RL2
      psm_pkg::MODE_PARAM: mode_step = psm_pkg::MODE_MONITOR; // RL2
      psm_pkg::MODE_MONITOR: mode_step = psm_pkg::MODE_UTILITY; // RL2
      psm_pkg::MODE_UTILITY: mode_step = psm_pkg::MODE_STATUS; // RL2
      default: mode_step = psm_pkg::MODE_STATUS;
    endcase
  end

  // a mode press while editing is spent on saving, so the mode stays put
  wire save_press = mode_press & edit_q;
  wire in_status = (mode_q == psm_pkg::MODE_STATUS);
  wire in_param = (mode_q == psm_pkg::MODE_PARAM);

  always_comb begin
    mode_d = mode_q;
    if (mode_press && !edit_q) begin
      mode_d = mode_step; // RL1
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= psm_pkg::MODE_STATUS; // RL3
    end else begin
      mode_q <= mode_d;
    end
  end

  // ------------------------------------------------------------
  // parameter editing
  // ------------------------------------------------------------
  wire at_max = (edit_val_q == psm_pkg::PARAM_MAX);
  wire at_min = (edit_val_q == psm_pkg::PARAM_MIN);

  always_comb begin
    edit_d = edit_q;
    edit_val_d = edit_val_q;
    if (!edit_q) begin
      if (in_param && enter_press) begin
        edit_d = 1'b1;
        edit_val_d = param_q;
      end
    end else if (save_press || enter_press) begin
      edit_d = 1'b0; // RL6
    end else if (inc_press && !at_max) begin
      edit_val_d = edit_val_q + 16'h0001; // RL7
    end else if (dec_press && !at_min) begin
      edit_val_d = edit_val_q - 16'h0001; // RL7
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      edit_q <= 1'b0;
      edit_val_q <= psm_pkg::RST_PARAM;
      commit_q <= 1'b0;
    end else begin
      edit_q <= edit_d;
      edit_val_q <= edit_val_d;
      commit_q <= save_press; // RL6
    end
  end

  // ------------------------------------------------------------
  // alarm clear
  // ------------------------------------------------------------
  wire panel_clear = enter_press & in_status & ~edit_q; // RL4

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clear_q <= 1'b0;
    end else begin
      clear_q <= panel_clear | alm_clr_press; // RL5
    end
  end

  // ------------------------------------------------------------
  // register file over the AXI4-Lite slave
  // ------------------------------------------------------------
  logic [15:0] spd_thr_q;
  logic [15:0] pos_thr_q;
  logic [15:0] rot_thr_q;
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic [6:0] bits_q;
  logic [7:0] code_q;
  logic alarm_q;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
    merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
  endfunction : merge16

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] base);
    hit = (addr[7:2] == base[7:2]);
  endfunction : hit

  wire aw_take = s_axi_awvalid & ~aw_held_q & ~bvalid_q;
  wire w_take = s_axi_wvalid & ~w_held_q & ~bvalid_q;
  wire do_write = aw_held_q & w_held_q & ~bvalid_q;
  wire wr_spd = do_write & hit(awaddr_q, psm_pkg::ADDR_SPEED_MATCH);
  wire wr_pos = do_write & hit(awaddr_q, psm_pkg::ADDR_POS_DONE);
  wire wr_rot = do_write & hit(awaddr_q, psm_pkg::ADDR_ROT_SPEED);
  wire wr_par = do_write & hit(awaddr_q, psm_pkg::ADDR_PARAM);
  wire wr_sts = do_write & hit(awaddr_q, psm_pkg::ADDR_STATUS);
  wire wr_ok = wr_spd | wr_pos | wr_rot | wr_par | wr_sts;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_q <= 1'b0;
      end
      if (w_take) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= psm_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_ok ? psm_pkg::RESP_OKAY : psm_pkg::RESP_DECERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // the panel save takes priority over a software write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      spd_thr_q <= psm_pkg::RST_SPEED_MATCH;
      pos_thr_q <= psm_pkg::RST_POS_DONE;
      rot_thr_q <= psm_pkg::RST_ROT_SPEED;
      param_q <= psm_pkg::RST_PARAM;
    end else begin
      if (wr_spd) spd_thr_q <= merge16(spd_thr_q, wdata_q, wstrb_q);
      if (wr_pos) pos_thr_q <= merge16(pos_thr_q, wdata_q, wstrb_q);
      if (wr_rot) rot_thr_q <= merge16(rot_thr_q, wdata_q, wstrb_q);
      if (save_press) begin
        param_q <= edit_val_q; // RL6
      end else if (wr_par) begin
        param_q <= merge16(param_q, wdata_q, wstrb_q);
      end
    end
  end

  // ------------------------------------------------------------
  // read channel
  // ------------------------------------------------------------
  wire ar_take = s_axi_arvalid & ~rvalid_q;
  wire [31:0] status_word = {7'h00, alarm_q, code_q, 1'b0, bits_q, 3'h0, edit_q, mode_q};
  wire rd_spd = hit(s_axi_araddr, psm_pkg::ADDR_SPEED_MATCH);
  wire rd_pos = hit(s_axi_araddr, psm_pkg::ADDR_POS_DONE);
  wire rd_rot = hit(s_axi_araddr, psm_pkg::ADDR_ROT_SPEED);
  wire rd_par = hit(s_axi_araddr, psm_pkg::ADDR_PARAM);
  wire rd_sts = hit(s_axi_araddr, psm_pkg::ADDR_STATUS);
  wire [31:0] rd_word = rd_spd ? {16'h0000, spd_thr_q} :
                        rd_pos ? {16'h0000, pos_thr_q} :
                        rd_rot ? {16'h0000, rot_thr_q} :
                        rd_par ? {16'h0000, param_q} :
                        rd_sts ? status_word : 32'h0000_0000;
  wire rd_ok = rd_spd | rd_pos | rd_rot | rd_par | rd_sts;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q <= psm_pkg::RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rresp_q <= rd_ok ? psm_pkg::RESP_OKAY : psm_pkg::RESP_DECERR;
      rdata_q <= rd_word;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // status indicators
  // ------------------------------------------------------------
  wire pos_ctrl = (control_mode == psm_pkg::CTRL_POSITION); // RL8
  wire trq_ctrl = (control_mode == psm_pkg::CTRL_TORQUE);
  wire spd_match = trq_ctrl | (speed_error <= spd_thr_q); // RL9
  wire pos_done = (position_error < pos_thr_q); // RL10
  wire ref_above = (speed_reference > rot_thr_q); // RL13
  wire trq_above = (torque_reference_pct > psm_pkg::TORQUE_REF_PCT); // RL15
  wire rotating = (motor_speed > rot_thr_q); // RL18
  logic [6:0] bits_d;

  always_comb begin
    bits_d = 7'h00;
    bits_d[psm_pkg::IND_MATCH] = pos_ctrl ? pos_done : spd_match; // RL8
    bits_d[psm_pkg::IND_BASE_BLOCK] = base_block & ~servo_on; // RL11
    bits_d[psm_pkg::IND_CTRL_POWER] = control_power_ok; // RL12
    bits_d[psm_pkg::IND_REF] = pos_ctrl ? reference_pulse_active : ref_above; // RL14
    bits_d[psm_pkg::IND_TORQUE_CLR] = pos_ctrl ? error_clear_active : trq_above; // RL16
    bits_d[psm_pkg::IND_POWER_READY] = main_power_ok; // RL17
    bits_d[psm_pkg::IND_ROTATION] = rotating; // RL18
  end

  // ------------------------------------------------------------
  // status code, alarm first, then limits, then run state
  // ------------------------------------------------------------
  wire [7:0] code_d = alarm_pending ? alarm_number : // RL21
                      !fwd_ok ? psm_pkg::CODE_FWD_PROHIBIT : // RL20
                      !rev_ok ? psm_pkg::CODE_REV_PROHIBIT : // RL20
                      servo_on ? psm_pkg::CODE_RUN : psm_pkg::CODE_BASEBLOCK; // RL19

  // indicator registers stay live in every mode so software can always read them; status_bits shows them only in status mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bits_q <= 7'h00;
      code_q <= psm_pkg::CODE_BASEBLOCK;
      alarm_q <= 1'b0;
    end else begin
      bits_q <= bits_d;
      code_q <= code_d;
      alarm_q <= alarm_pending; // RL21
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign s_axi_awready = ~aw_held_q & ~bvalid_q;
  assign s_axi_wready = ~w_held_q & ~bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign basic_mode = mode_q;
  assign editing = edit_q;
  assign edit_value = edit_val_q;
  assign param_commit = commit_q;
  assign alarm_clear = clear_q;
  assign status_bits = in_status ? bits_q : 7'h00;
  assign status_code = in_status ? code_q : 8'h00;
  assign status_alarm = in_status & alarm_q;

endmodule : psm_panel

// ### bench/psm_panel_props.sv
// concurrent checks on the panel logic ports
`timescale 1ns/10ps
module psm_panel_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic alarm_clear_input,
  input wire logic [1:0] control_mode,
  input wire logic servo_on,
  input wire logic base_block,
  input wire logic control_power_ok,
  input wire logic main_power_ok,
  input wire logic alarm_pending,
  input wire logic [7:0] alarm_number,
  input wire logic [3:0] basic_mode,
  input wire logic editing,
  input wire logic [15:0] edit_value,
  input wire logic param_commit,
  input wire logic alarm_clear,
  input wire logic [6:0] status_bits,
  input wire logic [7:0] status_code,
  input wire logic status_alarm
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // --------------------------------------------------------
  // properties
  // --------------------------------------------------------
  // settled: two cycles in status mode after a clean reset edge
  wire logic sts_stable;
  logic sts_q;
  always_ff @(posedge aclk) sts_q <= aresetn && basic_mode == 4'h1;
  assign sts_stable = sts_q && basic_mode == 4'h1;
  property p_reset_mode; $rose(aresetn) |-> basic_mode == 4'h1; endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("mode after reset not status");
  property p_mode_step;
    $changed(basic_mode) |-> basic_mode == {$past(basic_mode[2:0]), $past(basic_mode[3])};
  endproperty
  a_mode_step: assert property (p_mode_step) else $error("mode step out of sequence");
  property p_base_block;
    sts_stable |-> status_bits[psm_pkg::IND_BASE_BLOCK] == $past(base_block && !servo_on);
  endproperty
  a_base_block: assert property (p_base_block) else $error("base block bit wrong");
  property p_ctrl_power; sts_stable |-> status_bits[psm_pkg::IND_CTRL_POWER] == $past(control_power_ok); endproperty
  a_ctrl_power: assert property (p_ctrl_power) else $error("control power bit wrong");
  property p_power_ready; sts_stable |-> status_bits[psm_pkg::IND_POWER_READY] == $past(main_power_ok); endproperty
  a_power_ready: assert property (p_power_ready) else $error("power ready bit wrong");
  property p_torque_match;
    sts_stable && $past(control_mode) == psm_pkg::CTRL_TORQUE |-> status_bits[psm_pkg::IND_MATCH];
  endproperty
  a_torque_match: assert property (p_torque_match) else $error("match bit dark in torque mode");
  property p_alarm_code;
    sts_stable && $past(alarm_pending) |-> status_code == $past(alarm_number) && status_alarm;
  endproperty
  a_alarm_code: assert property (p_alarm_code) else $error("alarm number not shown");
  property p_step_one;
    editing && $past(editing) && $changed(edit_value) |->
      edit_value == $past(edit_value) + 16'h1 || edit_value == $past(edit_value) - 16'h1;
  endproperty
  a_step_one: assert property (p_step_one) else $error("edit value moved by more than one");
  property p_commit; $rose(param_commit) |-> $fell(editing) && basic_mode == 4'h2; endproperty
  a_commit: assert property (p_commit) else $error("save without leaving edit");
  property p_ext_clear; $rose(alarm_clear_input) |-> ##[1:6] alarm_clear; endproperty
  a_ext_clear: assert property (p_ext_clear) else $error("external clear gave no pulse");
endmodule : psm_panel_props

bind psm_panel psm_panel_props chk_u (.aclk, .aresetn, .alarm_clear_input, .control_mode, .servo_on, .base_block,
  .control_power_ok, .main_power_ok, .alarm_pending, .alarm_number, .basic_mode, .editing, .edit_value,
  .param_commit, .alarm_clear, .status_bits, .status_code, .status_alarm);

// ### bench/psm_keypad_model.sv
// front panel key model: one press at a time, released before the next
`timescale 1ns/10ps
module psm_keypad_model (
  input wire logic aclk,
  output logic mode_key,
  output logic enter_key,
  output logic increment_key,
  output logic decrement_key
);
  initial {decrement_key, increment_key, enter_key, mode_key} = 4'h0;
  // k one-hot {dec, inc, enter, mode}; low gap keeps presses apart
  task automatic press(input logic [3:0] k);
    @(posedge aclk);
    {decrement_key, increment_key, enter_key, mode_key} <= k;
    repeat (3) @(posedge aclk);
    {decrement_key, increment_key, enter_key, mode_key} <= 4'h0;
    repeat (4) @(posedge aclk);
  endtask : press
endmodule : psm_keypad_model

// ### bench/tb_psm_panel.sv
// self-checking bench for the panel status and mode logic
`timescale 1ns/10ps
module tb_psm_panel;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic mode_key, enter_key, increment_key, decrement_key;
  logic alarm_clear_input = 1'b0, forward_limit_input = 1'b1, reverse_limit_input = 1'b1;
  logic [1:0] control_mode = 2'h0;
  logic [15:0] speed_error = 16'h0, position_error = 16'h0, speed_reference = 16'h0, motor_speed = 16'h0;
  logic servo_on = 1'b0, base_block = 1'b0, control_power_ok = 1'b0, main_power_ok = 1'b0;
  logic reference_pulse_active = 1'b0, error_clear_active = 1'b0, alarm_pending = 1'b0;
  logic [7:0] torque_reference_pct = 8'h00, alarm_number = 8'h00;
  logic [3:0] basic_mode;
  logic editing, param_commit, alarm_clear, status_alarm;
  logic [15:0] edit_value;
  logic [6:0] status_bits;
  logic [7:0] status_code;
  int n_fail = 0, cmp_count = 0, n_clr = 0, n_commit = 0, cyc = 0;

  always #25 aclk = ~aclk;

  psm_keypad_model kp_u (.*);
  psm_panel dut_u (.*);

  // --------------------------------------------------------
  // pulse counters and hang guard
  // --------------------------------------------------------
  always @(posedge aclk) begin
    if (alarm_clear === 1'b1) n_clr++;
    if (param_commit === 1'b1) n_commit++;
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
  endtask : axi_rd

  // flags {base_block, servo_on, ctrl power, main power, ref pulse, error clear}
  task automatic drv(input logic [1:0] cm, input logic [15:0] se, input logic [15:0] pe, input logic [15:0] sr,
                     input logic [7:0] tq, input logic [15:0] ms, input logic [5:0] f);
    control_mode <= cm;
    speed_error <= se;
    position_error <= pe;
    speed_reference <= sr;
    torque_reference_pct <= tq;
    motor_speed <= ms;
    {base_block, servo_on, control_power_ok, main_power_ok, reference_pulse_active, error_clear_active} <= f;
    repeat (5) @(posedge aclk);
  endtask : drv

  // v {alarm pending, fwd ok, rev ok, servo on}; code checked with its alarm flag
  task automatic sc(input logic [3:0] v, input logic [8:0] e);
    {alarm_pending, forward_limit_input, reverse_limit_input, servo_on} <= v;
    alarm_number <= e[7:0];
    repeat (6) @(posedge aclk);
    chk({status_alarm, status_code}, e);
  endtask : sc

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  // --------------------------------------------------------
  // main sequence
  // --------------------------------------------------------
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(basic_mode, 4'h1);
    axi_rd(psm_pkg::ADDR_SPEED_MATCH, {16'h0, psm_pkg::RST_SPEED_MATCH}, psm_pkg::RESP_OKAY);
    axi_rd(psm_pkg::ADDR_ROT_SPEED, {16'h0, psm_pkg::RST_ROT_SPEED}, psm_pkg::RESP_OKAY);
    axi_rd(8'h20, 32'h0, psm_pkg::RESP_DECERR);
    axi_wr(8'h20, 32'h1234, 4'hf, psm_pkg::RESP_DECERR);
    axi_wr(psm_pkg::ADDR_PARAM, 32'hfffe, 4'hf, psm_pkg::RESP_OKAY);
    kp_u.press(4'h1);
    chk(basic_mode, 4'h2);
    kp_u.press(4'h2);
    chk(edit_value, 16'hfffe);
    kp_u.press(4'h4);
    chk(edit_value, 16'hffff);
    kp_u.press(4'h4);
    chk(edit_value, 16'hffff);
    kp_u.press(4'h8);
    kp_u.press(4'h8);
    chk(edit_value, 16'hfffd);
    kp_u.press(4'h1);
    chk(editing, 1'b0);
    chk(basic_mode, 4'h2);
    chk(n_commit, 1);
    axi_rd(psm_pkg::ADDR_PARAM, 32'hfffd, psm_pkg::RESP_OKAY);
    for (int i = 0; i < 3; i++) begin
      kp_u.press(4'h1);
      chk(basic_mode, (i < 2) ? 4'h4 << i : 4'h1);
    end
    drv(psm_pkg::CTRL_SPEED, 16'd10, 16'd0, 16'd21, 8'd11, 16'd20, 6'b101001);
    chk(status_bits, 7'h1f);
    drv(psm_pkg::CTRL_TORQUE, 16'd11, 16'd0, 16'd20, 8'd10, 16'd21, 6'b010100);
    chk(status_bits, 7'h61);
    drv(psm_pkg::CTRL_POSITION, 16'd0, 16'd9, 16'd0, 8'd0, 16'd0, 6'b111110);
    chk(status_bits, 7'h2d);
    drv(psm_pkg::CTRL_POSITION, 16'd0, 16'd10, 16'd0, 8'd0, 16'd21, 6'b100001);
    chk(status_bits, 7'h52);
    axi_wr(psm_pkg::ADDR_ROT_SPEED, 32'd30, 4'hf, psm_pkg::RESP_OKAY);
    axi_wr(psm_pkg::ADDR_SPEED_MATCH, 32'd5, 4'hf, psm_pkg::RESP_OKAY);
    axi_wr(psm_pkg::ADDR_POS_DONE, 32'h1234, 4'h2, psm_pkg::RESP_OKAY);
    axi_rd(psm_pkg::ADDR_POS_DONE, 32'h120a, psm_pkg::RESP_OKAY);
    drv(psm_pkg::CTRL_SPEED, 16'd6, 16'd0, 16'd21, 8'd0, 16'd25, 6'b011100);
    chk(status_bits, 7'h24);
    sc(4'b1111, 9'h15a);
    kp_u.press(4'h2);
    chk(n_clr, 1);
    alarm_clear_input <= 1'b1;
    repeat (3) @(posedge aclk);
    alarm_clear_input <= 1'b0;
    repeat (4) @(posedge aclk);
    chk(n_clr, 2);
    sc(4'b0011, psm_pkg::CODE_FWD_PROHIBIT);
    sc(4'b0101, psm_pkg::CODE_REV_PROHIBIT);
    sc(4'b0111, psm_pkg::CODE_RUN);
    sc(4'b0110, psm_pkg::CODE_BASEBLOCK);
    conclude();
  end
endmodule : tb_psm_panel
